// [rtl/dspa_addr_map.sv]
`timescale 1ns/1ps
`include "dspa_consts.svh"
module dspa_addr_map (
  input  wire logic            we_in,
  input  wire dspa_pkg::dspa_word_t base_effective_addr_in,
  input  wire logic [9:0]      read_page_in,
  input  wire logic [8:0]      write_page_in,
  output dspa_pkg::dspa_ext_addr_t ext_addr_out,
  output logic                 page_err_out
);
  import dspa_pkg::*;

  logic [8:0] page;

  always_comb begin
    page         = we_in ? write_page_in : read_page_in[8:0];
    page_err_out = 1'b0;
    if (!base_effective_addr_in[`DSPA_ADDR_UPPER]) begin
      ext_addr_out = {8'h00, base_effective_addr_in};
    end else begin
      ext_addr_out = {page, base_effective_addr_in[14:0]};
      page_err_out = we_in ? (write_page_in == 9'h000)
                           : (read_page_in == 10'h000);
    end
  end
endmodule // dspa_addr_map

// [rtl/dspa_arbiter.sv]
`timescale 1ns/1ps
`include "dspa_consts.svh"
module dspa_arbiter (
  input  wire logic [2:0]         req_in,
  input  wire logic               dma_first_in,
  output logic [2:0]              grant_out,
  output dspa_pkg::dspa_master_e  sel_out
);
  import dspa_pkg::*;

  // Raised and lowered groups each keep their own order; debug always last
  always_comb begin
    grant_out = 3'h0;
    sel_out   = DSPA_CPU;
    if (dma_first_in && req_in[`DSPA_M_DMA]) begin
      grant_out[`DSPA_M_DMA] = 1'b1;
      sel_out                = DSPA_DMA;
    end else if (req_in[`DSPA_M_CPU]) begin
      grant_out[`DSPA_M_CPU] = 1'b1;
      sel_out                = DSPA_CPU;
    end else if (req_in[`DSPA_M_DMA]) begin
      grant_out[`DSPA_M_DMA] = 1'b1;
      sel_out                = DSPA_DMA;
    end else if (req_in[`DSPA_M_DBG]) begin
      grant_out[`DSPA_M_DBG] = 1'b1;
      sel_out                = DSPA_DBG;
    end
  end
endmodule // dspa_arbiter

// [rtl/dspa_consts.svh]
`ifndef DSPA_CONSTS_SVH
`define DSPA_CONSTS_SVH

// Register word offsets
`define DSPA_OFS_READ_PAGE   4'h0
`define DSPA_OFS_WRITE_PAGE  4'h1
`define DSPA_OFS_PRIORITY    4'h2
`define DSPA_OFS_IRQ_STATUS  4'h3
`define DSPA_OFS_IRQ_CLEAR   4'h4
`define DSPA_OFS_IRQ_ENABLE  4'h5
`define DSPA_OFS_TRAP_LO     4'h6
`define DSPA_OFS_TRAP_HI     4'h7
`define DSPA_OFS_STATUS      4'h8

// Reset values
`define DSPA_READ_PAGE_RST   10'h001
`define DSPA_WRITE_PAGE_RST  9'h001
`define DSPA_PRIORITY_RST    16'h0000

// Priority encodings
`define DSPA_PRIO_DEFAULT    16'h0000
`define DSPA_PRIO_DMA_HIGH   16'h0020

// Field positions
`define DSPA_ADDR_UPPER      15
`define DSPA_RPAGE_WINDOW    9
`define DSPA_IRQ_TRAP        0
`define DSPA_IRQ_STALL       1
`define DSPA_M_CPU           0
`define DSPA_M_DMA           1
`define DSPA_M_DBG           2

`endif

// [rtl/dspa_pkg.sv]
package dspa_pkg;

  typedef enum logic [1:0] {DSPA_CPU, DSPA_DMA, DSPA_DBG} dspa_master_e;

  typedef logic [23:0] dspa_ext_addr_t;
  typedef logic [15:0] dspa_word_t;

  typedef struct packed {
    logic [9:0]     read_page;
    logic [8:0]     write_page;
    dspa_word_t     prio;
    logic [1:0]     irq_status;
    logic [1:0]     irq_enable;
    dspa_ext_addr_t trap_addr;
    dspa_word_t     rdata;
    logic [2:0]     grant;
    logic           mem_req;
    logic           mem_we;
    dspa_ext_addr_t mem_addr;
    dspa_master_e   mem_master;
    logic           trap;
    logic           irq;
  } dspa_state_s;

endpackage

// [rtl/dspa_top.sv]
`timescale 1ns/1ps
`include "dspa_consts.svh"
module dspa_top (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic [3:0]           reg_addr_in,
  input  wire dspa_pkg::dspa_word_t reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output dspa_pkg::dspa_word_t      reg_rdata_out,
  input  wire logic                 cpu_req_in,
  input  wire logic                 cpu_we_in,
  input  wire dspa_pkg::dspa_word_t cpu_addr_in,
  input  wire logic                 dma_req_in,
  input  wire logic                 dma_we_in,
  input  wire dspa_pkg::dspa_word_t dma_addr_in,
  input  wire logic                 dbg_req_in,
  input  wire logic                 dbg_we_in,
  input  wire dspa_pkg::dspa_word_t dbg_addr_in,
  output logic                      cpu_grant_out,
  output logic                      dma_grant_out,
  output logic                      dbg_grant_out,
  output logic                      mem_req_out,
  output logic                      mem_we_out,
  output dspa_pkg::dspa_ext_addr_t  mem_addr_out,
  output dspa_pkg::dspa_master_e    mem_master_out,
  output logic                      addr_trap_out,
  output logic                      irq_out
);
  import dspa_pkg::*;

  dspa_state_s    st_q;
  dspa_state_s    st_d;
  logic [2:0]     req_raw;
  logic [2:0]     req_eff;
  logic [2:0]     grant_c;
  dspa_master_e   sel_c;
  logic           sel_we;
  dspa_word_t     sel_addr;
  dspa_ext_addr_t map_addr;
  logic           map_err;
  logic           dma_first;
  logic           prio_reserved;
  logic [1:0]     ev;
  logic [1:0]     clr;

  assign req_raw = {dbg_req_in, dma_req_in, cpu_req_in};
  // A master just granted sees its grant now; its held request is not retaken
  assign req_eff = req_raw & ~st_q.grant;
  assign dma_first = (st_q.prio == `DSPA_PRIO_DMA_HIGH);
  // Reserved priority values fall back to the default order
  assign prio_reserved = (st_q.prio != `DSPA_PRIO_DEFAULT) && !dma_first;

  dspa_arbiter u_arb (
    .req_in       (req_eff),
    .dma_first_in (dma_first),
    .grant_out    (grant_c),
    .sel_out      (sel_c)
  );

  always_comb begin
    unique case (sel_c)
      DSPA_CPU: begin
        sel_we   = cpu_we_in;
        sel_addr = cpu_addr_in;
      end
      DSPA_DMA: begin
        sel_we   = dma_we_in;
        sel_addr = dma_addr_in;
      end
      DSPA_DBG: begin
        sel_we   = dbg_we_in;
        sel_addr = dbg_addr_in;
      end
      default: begin
        sel_we   = 1'b0;
        sel_addr = 16'h0000;
      end
    endcase
  end

  dspa_addr_map u_map (
    .we_in                  (sel_we),
    .base_effective_addr_in (sel_addr),
    .read_page_in           (st_q.read_page),
    .write_page_in          (st_q.write_page),
    .ext_addr_out           (map_addr),
    .page_err_out           (map_err)
  );

  always_comb begin
    st_d         = st_q;
    st_d.trap    = 1'b0;
    st_d.mem_req = 1'b0;
    st_d.grant   = 3'h0;
    st_d.rdata   = 16'h0000;
    clr          = 2'h0;
    ev           = 2'h0;

    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `DSPA_OFS_READ_PAGE: begin
          if (reg_wdata_in[9:0] != 10'h000) begin
            st_d.read_page = reg_wdata_in[9:0];
          end
        end
        `DSPA_OFS_WRITE_PAGE: begin
          if (reg_wdata_in[8:0] != 9'h000) begin
            st_d.write_page = reg_wdata_in[8:0];
          end
        end
        `DSPA_OFS_PRIORITY:   st_d.prio = reg_wdata_in;
        `DSPA_OFS_IRQ_CLEAR:  clr = reg_wdata_in[1:0];
        `DSPA_OFS_IRQ_ENABLE: st_d.irq_enable = reg_wdata_in[1:0];
        default: ;
      endcase
    end

    if (|grant_c) begin
      st_d.grant      = grant_c;
      st_d.mem_we     = sel_we;
      st_d.mem_addr   = map_addr;
      st_d.mem_master = sel_c;
      if (map_err) begin
        st_d.trap      = 1'b1;
        st_d.trap_addr = map_addr;
        ev[`DSPA_IRQ_TRAP] = 1'b1;
      end else begin
        st_d.mem_req = 1'b1;
      end
    end
    // Losers stay suspended and are counted as a stall event
    ev[`DSPA_IRQ_STALL] = |(req_eff & ~grant_c);

    // A new event wins over a clear in the same cycle
    st_d.irq_status = (st_q.irq_status & ~clr) | ev;
    st_d.irq        = |(st_d.irq_status & st_d.irq_enable);

    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `DSPA_OFS_READ_PAGE:  st_d.rdata = {6'h00, st_q.read_page};
        `DSPA_OFS_WRITE_PAGE: st_d.rdata = {7'h00, st_q.write_page};
        `DSPA_OFS_PRIORITY:   st_d.rdata = st_q.prio;
        `DSPA_OFS_IRQ_STATUS: st_d.rdata = {14'h0000, st_q.irq_status};
        `DSPA_OFS_IRQ_ENABLE: st_d.rdata = {14'h0000, st_q.irq_enable};
        `DSPA_OFS_TRAP_LO:    st_d.rdata = st_q.trap_addr[15:0];
        `DSPA_OFS_TRAP_HI:    st_d.rdata = {8'h00, st_q.trap_addr[23:16]};
        `DSPA_OFS_STATUS:     st_d.rdata = {12'h000, dma_first, prio_reserved,
                                            st_q.mem_master};
        default:              st_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q            <= '0;
      st_q.read_page  <= `DSPA_READ_PAGE_RST;
      st_q.write_page <= `DSPA_WRITE_PAGE_RST;
      st_q.prio       <= `DSPA_PRIORITY_RST;
      st_q.mem_master <= DSPA_CPU;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out  = st_q.rdata;
  assign cpu_grant_out  = st_q.grant[`DSPA_M_CPU];
  assign dma_grant_out  = st_q.grant[`DSPA_M_DMA];
  assign dbg_grant_out  = st_q.grant[`DSPA_M_DBG];
  assign mem_req_out    = st_q.mem_req;
  assign mem_we_out     = st_q.mem_we;
  assign mem_addr_out   = st_q.mem_addr;
  assign mem_master_out = st_q.mem_master;
  assign addr_trap_out  = st_q.trap;
  assign irq_out        = st_q.irq;

  property p_pages_nonzero;
    @(posedge clk_in) disable iff (!resetn_in)
      (st_q.read_page != 10'h000) && (st_q.write_page != 9'h000);
  endproperty
  a_pages_nonzero: assert property (p_pages_nonzero)
    else $error("page register holds zero");

  property p_zero_write_kept;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_addr_in == `DSPA_OFS_READ_PAGE && reg_wdata_in[9:0] == 10'h000)
      |=> (st_q.read_page == $past(st_q.read_page));
  endproperty
  a_zero_write_kept: assert property (p_zero_write_kept)
    else $error("zero write changed read page");

  property p_read_addr;
    @(posedge clk_in) disable iff (!resetn_in)
      (|grant_c && !sel_we && sel_addr[15] && !st_q.read_page[9] && !map_err)
      |=> mem_req_out && !mem_we_out
          && mem_addr_out == {$past(st_q.read_page[8:0]), $past(sel_addr[14:0])};
  endproperty
  a_read_addr: assert property (p_read_addr)
    else $error("upper read address wrong");

  property p_write_addr;
    @(posedge clk_in) disable iff (!resetn_in)
      (|grant_c && sel_we && sel_addr[15] && !map_err)
      |=> mem_req_out && mem_we_out
          && mem_addr_out == {$past(st_q.write_page), $past(sel_addr[14:0])};
  endproperty
  a_write_addr: assert property (p_write_addr)
    else $error("upper write address wrong");

  property p_low_pass;
    @(posedge clk_in) disable iff (!resetn_in)
      (|grant_c && !sel_addr[15])
      |=> mem_req_out && !addr_trap_out && mem_addr_out == {8'h00, $past(sel_addr)};
  endproperty
  a_low_pass: assert property (p_low_pass)
    else $error("lower half not passed through");

  property p_trap;
    @(posedge clk_in) disable iff (!resetn_in)
      (|grant_c && map_err) |=> addr_trap_out && !mem_req_out ##1 !addr_trap_out;
  endproperty
  a_trap: assert property (p_trap)
    else $error("page zero access not trapped");

  property p_default_order;
    @(posedge clk_in) disable iff (!resetn_in)
      (req_eff[0] && req_eff[1] && st_q.prio == `DSPA_PRIO_DEFAULT)
      |=> cpu_grant_out && !dma_grant_out && !dbg_grant_out;
  endproperty
  a_default_order: assert property (p_default_order)
    else $error("CPU not first by default");

  property p_raised_order;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_addr_in == `DSPA_OFS_PRIORITY
       && reg_wdata_in == `DSPA_PRIO_DMA_HIGH)
      ##1 (req_eff[0] && req_eff[1] && !reg_wr_in)
      |=> dma_grant_out && !cpu_grant_out;
  endproperty
  a_raised_order: assert property (p_raised_order)
    else $error("DMA not first after priority write");

  property p_dbg_last;
    @(posedge clk_in) disable iff (!resetn_in)
      dbg_grant_out |-> !$past(req_eff[0]) && !$past(req_eff[1]);
  endproperty
  a_dbg_last: assert property (p_dbg_last)
    else $error("debug granted over a higher master");

  property p_one_grant;
    @(posedge clk_in) disable iff (!resetn_in)
      $onehot0({cpu_grant_out, dma_grant_out, dbg_grant_out})
      && (mem_req_out || addr_trap_out) == (cpu_grant_out || dma_grant_out || dbg_grant_out);
  endproperty
  a_one_grant: assert property (p_one_grant)
    else $error("more than one grant in a cycle");

  property p_served_later;
    @(posedge clk_in) disable iff (!resetn_in)
      (req_eff[0] && req_eff[1] && !dma_first && !reg_wr_in) ##1 dma_req_in
      |=> dma_grant_out;
  endproperty
  a_served_later: assert property (p_served_later)
    else $error("suspended master not served next");

  property p_irq_level;
    @(posedge clk_in) disable iff (!resetn_in)
      irq_out == |(st_q.irq_status & st_q.irq_enable);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status");

  property p_wpage_zero_kept;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_addr_in == `DSPA_OFS_WRITE_PAGE && reg_wdata_in[8:0] == 9'h000)
      |=> (st_q.write_page == $past(st_q.write_page));
  endproperty
  a_wpage_zero_kept: assert property (p_wpage_zero_kept)
    else $error("zero write changed write page");

  property p_rpage_taken;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_addr_in == `DSPA_OFS_READ_PAGE && reg_wdata_in[9:0] != 10'h000)
      |=> (st_q.read_page == $past(reg_wdata_in[9:0]));
  endproperty
  a_rpage_taken: assert property (p_rpage_taken)
    else $error("read page write lost");

  property p_wpage_taken;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_addr_in == `DSPA_OFS_WRITE_PAGE && reg_wdata_in[8:0] != 9'h000)
      |=> (st_q.write_page == $past(reg_wdata_in[8:0]));
  endproperty
  a_wpage_taken: assert property (p_wpage_taken)
    else $error("write page write lost");

  property p_page0_window;
    @(posedge clk_in) disable iff (!resetn_in)
      (|grant_c && sel_addr <= 16'h2FFF)
      |=> mem_req_out && mem_addr_out <= 24'h002FFF;
  endproperty
  a_page0_window: assert property (p_page0_window)
    else $error("low address left page zero");

  property p_dma_first_order;
    @(posedge clk_in) disable iff (!resetn_in)
      (req_eff[0] && req_eff[1] && st_q.prio == `DSPA_PRIO_DMA_HIGH)
      |=> dma_grant_out && !cpu_grant_out;
  endproperty
  a_dma_first_order: assert property (p_dma_first_order)
    else $error("DMA not first under raised priority");

  property p_stall_sets;
    @(posedge clk_in) disable iff (!resetn_in)
      (|(req_eff & ~grant_c)) |=> st_q.irq_status[`DSPA_IRQ_STALL];
  endproperty
  a_stall_sets: assert property (p_stall_sets)
    else $error("suspended request not flagged");

  property p_status_sticky;
    @(posedge clk_in) disable iff (!resetn_in)
      (st_q.irq_status[`DSPA_IRQ_STALL]
       && !(reg_wr_in && reg_addr_in == `DSPA_OFS_IRQ_CLEAR && reg_wdata_in[1]))
      |=> st_q.irq_status[`DSPA_IRQ_STALL];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("stall status dropped without a clear");

  property p_rdata_idle;
    @(posedge clk_in) disable iff (!resetn_in)
      !reg_rd_in |=> (reg_rdata_out == 16'h0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");

endmodule // dspa_top

// [sim/dspa_master_model.sv]
`timescale 1ns/1ps
module dspa_master_model (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 start_in,
  input  wire logic                 start_we_in,
  input  wire dspa_pkg::dspa_word_t start_addr_in,
  input  wire logic                 grant_in,
  output logic                      req_out,
  output logic                      we_out,
  output dspa_pkg::dspa_word_t      addr_out
);
  import dspa_pkg::*;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_out  <= 1'b0;
      we_out   <= 1'b0;
      addr_out <= 16'h0000;
    end else if (start_in && !req_out) begin
      req_out  <= 1'b1;
      we_out   <= start_we_in;
      addr_out <= start_addr_in;
    end else if (req_out && grant_in) begin
      // Released lines show the inverse, not a stale copy
      req_out  <= 1'b0;
      we_out   <= ~we_out;
      addr_out <= ~addr_out;
    end
  end
endmodule // dspa_master_model

// [sim/testbench.sv]
`timescale 1ns/1ps
`include "dspa_consts.svh"
module testbench;
  import dspa_pkg::*;
  logic           clk_in       = 1'b0;
  logic           resetn_in    = 1'b0;
  logic [3:0]     reg_addr_in  = 4'h0;
  dspa_word_t     reg_wdata_in = 16'h0000;
  logic           reg_wr_in    = 1'b0;
  logic           reg_rd_in    = 1'b0;
  logic [2:0]     start        = 3'b000;
  logic [2:0]     start_we     = 3'b000;
  dspa_word_t     start_addr [3] = '{default: 16'h0000};
  wire  [2:0]     req;
  wire  [2:0]     we;
  wire  [2:0]     gnt;
  wire  [15:0]    mst_addr [3];
  dspa_word_t     reg_rdata_out;
  logic           mem_req_out, mem_we_out, addr_trap_out, irq_out;
  dspa_ext_addr_t mem_addr_out;
  dspa_master_e   mem_master_out;
  dspa_master_e   got_m [$];
  dspa_ext_addr_t got_a [$];
  logic           got_w [$];
  logic [9:0]     rp_v = 10'h001;
  logic [8:0]     wp_v = 9'h001;
  int             err_total = 0;
  int             num_checks = 0;
  int             trap_cnt = 0;

  always #50 clk_in = ~clk_in;

  dspa_top i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cpu_req_in(req[0]), .cpu_we_in(we[0]),
    .cpu_addr_in(mst_addr[0]), .dma_req_in(req[1]), .dma_we_in(we[1]),
    .dma_addr_in(mst_addr[1]), .dbg_req_in(req[2]), .dbg_we_in(we[2]),
    .dbg_addr_in(mst_addr[2]),
    .cpu_grant_out(gnt[0]), .dma_grant_out(gnt[1]), .dbg_grant_out(gnt[2]),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_master_out(mem_master_out), .addr_trap_out(addr_trap_out), .irq_out(irq_out)
  );

  for (genvar g = 0; g < 3; g++) begin : g_master
    dspa_master_model i_master (
      .clk_in(clk_in), .resetn_in(resetn_in), .start_in(start[g]),
      .start_we_in(start_we[g]), .start_addr_in(start_addr[g]), .grant_in(gnt[g]),
      .req_out(req[g]), .we_out(we[g]), .addr_out(mst_addr[g])
    );
  end

  always @(negedge clk_in) begin
    if (mem_req_out === 1'b1) begin
      got_m.push_back(mem_master_out);
      got_a.push_back(mem_addr_out);
      got_w.push_back(mem_we_out);
    end
    if (addr_trap_out === 1'b1) trap_cnt++;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic dspa_ext_addr_t exp_addr(input dspa_word_t a, input logic w);
    if (!a[15]) return {8'h00, a};
    return w ? {wp_v, a[14:0]} : {rp_v[8:0], a[14:0]};
  endfunction

  task automatic reg_wr(input logic [3:0] a, input dspa_word_t d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input dspa_word_t e, input string what);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    check(24'(reg_rdata_out), 24'(e), what);
  endtask

  // Zero in the low page bits must leave the old page in place
  task automatic set_pages(input dspa_word_t d);
    reg_wr(`DSPA_OFS_READ_PAGE, d & 16'hFDFF);
    reg_wr(`DSPA_OFS_WRITE_PAGE, d);
    if (d[8:0] != 9'h000) begin
      rp_v = {1'b0, d[8:0]};
      wp_v = d[8:0];
    end
    rd_chk(`DSPA_OFS_READ_PAGE, {6'h00, rp_v}, "read page");
    rd_chk(`DSPA_OFS_WRITE_PAGE, {7'h00, wp_v}, "write page");
  endtask

  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (got_m.size() < n && k < 40) begin
      @(negedge clk_in);
      k++;
    end
    repeat (3) @(negedge clk_in);
    check(24'(got_m.size()), 24'(n), "grant count");
  endtask

  task automatic access(input int m, input dspa_word_t a, input logic w);
    got_m.delete(); got_a.delete(); got_w.delete();
    @(posedge clk_in);
    start_addr[m] <= a;
    start_we[m]   <= w;
    start[m]      <= 1'b1;
    @(posedge clk_in);
    start[m] <= 1'b0;
    wait_q(1);
    if (got_m.size() > 0) begin
      check(got_a[0], exp_addr(a, w), "mapped addr");
      check(24'(got_w[0]), 24'(w), "direction");
      check(24'(got_m[0]), 24'(m), "single master");
    end
  endtask

  task automatic contend(input logic [2:0] mask, input dspa_word_t prio);
    dspa_master_e pref [3];
    dspa_word_t   ev [3];
    logic [2:0]   wv;
    int           j;
    if (prio == `DSPA_PRIO_DMA_HIGH) pref = '{DSPA_DMA, DSPA_CPU, DSPA_DBG};
    else pref = '{DSPA_CPU, DSPA_DMA, DSPA_DBG};
    reg_wr(`DSPA_OFS_PRIORITY, prio);
    got_m.delete(); got_a.delete(); got_w.delete();
    wv = 3'($urandom);
    @(posedge clk_in);
    for (int m = 0; m < 3; m++) begin
      ev[m] = 16'h8000 | 16'($urandom);
      start_addr[m] <= ev[m];
    end
    start_we <= wv;
    start    <= mask;
    @(posedge clk_in);
    start <= 3'b000;
    wait_q($countones(mask));
    j = 0;
    for (int i = 0; i < 3; i++) begin
      if (mask[pref[i]] && j < got_m.size()) begin
        check(24'(got_m[j]), 24'(pref[i]), "order");
        check(got_a[j], exp_addr(ev[pref[i]], wv[pref[i]]), "held addr");
        j++;
      end
    end
  endtask

  initial begin
    #(5000 * 100);
    err_total++;
    finish_test();
  end

  initial begin
    void'($urandom(46759));
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk(`DSPA_OFS_READ_PAGE, 16'h0001, "read page reset");
    rd_chk(`DSPA_OFS_WRITE_PAGE, 16'h0001, "write page reset");
    rd_chk(`DSPA_OFS_PRIORITY, 16'h0000, "priority reset");
    rd_chk(4'hF, 16'h0000, "unmapped");
    set_pages(16'h0000);
    set_pages(16'hFE00);
    access(0, 16'h8000, 1'b0);
    access(1, 16'hFFFF, 1'b1);
    set_pages(16'h0002);
    access(2, 16'h8000, 1'b1);
    access(0, 16'hFFFF, 1'b0);
    set_pages(16'h01FF);
    access(1, 16'h2FFF, 1'b0);
    access(2, 16'h7FFF, 1'b1);
    for (int n = 0; n < 40; n++) begin
      set_pages(16'($urandom));
      access($urandom_range(2, 0), 16'($urandom), 1'($urandom));
    end
    for (int p = 0; p < 2; p++) begin
      for (int k = 1; k < 8; k++) begin
        contend(3'(k), p ? `DSPA_PRIO_DMA_HIGH : `DSPA_PRIO_DEFAULT);
      end
    end
    reg_wr(`DSPA_OFS_IRQ_CLEAR, 16'h0003);
    rd_chk(`DSPA_OFS_IRQ_STATUS, 16'h0000, "status cleared");
    reg_wr(`DSPA_OFS_IRQ_ENABLE, 16'h0002);
    repeat (2) @(negedge clk_in);
    check(24'(irq_out), 24'h0, "irq idle");
    contend(3'b110, `DSPA_PRIO_DEFAULT);
    check(24'(irq_out), 24'h1, "irq raised");
    rd_chk(`DSPA_OFS_IRQ_STATUS, 16'h0002, "stall status");
    reg_wr(`DSPA_OFS_IRQ_CLEAR, 16'h0003);
    repeat (2) @(negedge clk_in);
    check(24'(irq_out), 24'h0, "irq cleared");
    reg_wr(`DSPA_OFS_IRQ_ENABLE, 16'h0000);
    contend(3'b011, `DSPA_PRIO_DMA_HIGH);
    check(24'(irq_out), 24'h0, "irq masked");
    rd_chk(`DSPA_OFS_STATUS, 16'h0008, "dma first status");
    reg_wr(`DSPA_OFS_IRQ_ENABLE, 16'h0002);
    repeat (2) @(negedge clk_in);
    check(24'(irq_out), 24'h1, "irq unmasked");
    check(24'(trap_cnt), 24'h0, "trap pulses");
    finish_test();
  end
endmodule // testbench
